// ===== src/fsp_map.svh
// Offsets, field positions, reset values and counts of the sweep profile block
`ifndef FSP_MAP_SVH
`define FSP_MAP_SVH

// APB byte offsets
`define FSP_OFF_CMD 8'h00
`define FSP_OFF_STATUS 8'h04
`define FSP_OFF_FREQ 8'h08
`define FSP_OFF_CONFIG 8'h0c

// Control word selector patterns
`define FSP_SEL4_CONTROL 4'h0
`define FSP_SEL4_COUNT 4'h1
`define FSP_SEL4_STEP_LO 4'h2
`define FSP_SEL4_STEP_HI 4'h3
`define FSP_SEL4_START_LO 4'hc
`define FSP_SEL4_START_HI 4'hd
`define FSP_SEL2_INTERVAL 2'h1
`define FSP_SEL3_BURST 3'h4

// Field positions inside a control word
`define FSP_BIT_FULL_WIDTH 11
`define FSP_BIT_CONTINUOUS 7
`define FSP_BIT_DIRECTION 11
`define FSP_BIT_UNIT_CLK 13
`define FSP_MULT_HI 12
`define FSP_MULT_LO 11

// Reset values of the control bits
`define FSP_RST_FULL_WIDTH 1'b1
`define FSP_RST_CONTINUOUS 1'b1

// Time-base multipliers in master clock periods
`define FSP_MULT_X1 9'h001
`define FSP_MULT_X5 9'h005
`define FSP_MULT_X100 9'h064
`define FSP_MULT_X500 9'h1f4

`endif

// ===== src/fsp_pkg.sv
// Types shared by the sweep profile block
package fsp_pkg;
   typedef enum logic [1:0] {
      FSP_IDLE = 2'b01,
      FSP_RUN = 2'b10
   } fsp_state_e;
   typedef logic [23:0] fsp_freq_t;
endpackage

// ===== src/fsp_sweep_top.sv
// Frequency sweep profile: control word decode, APB slave and sweep sequencer
//
// Chosen here: register access over APB and the register offsets.
`timescale 1ns/10ps
`include "fsp_map.svh"
module fsp_sweep_top
(
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic triggerPin,
   input wire logic waveCycleTick,
   output fsp_pkg::fsp_freq_t freqWord,
   output logic waveActive,
   output logic sweepBusy,
   output logic stepPulse,
   output logic sweepDonePulse
);
   import fsp_pkg::*;

   fsp_state_e state_ff, nxt_state;
   logic [31:0] prdata_ff;
   logic [15:0] cmdWord;
   logic [11:0] startLow_ff, startHigh_ff, pendLow_ff, stepLow_ff, stepCount_ff, stepIdx_ff;
   logic [10:0] stepHigh_ff, intCount_ff, burstCount_ff;
   logic [8:0] multLimit;
   logic [1:0] intMult_ff;
   fsp_freq_t freq_ff, nxt_freq, stepExt;
   logic pready_ff, pslverr_ff, stepDown_ff, intUnitClk_ff, burstUnitClk_ff, fullWidth_ff;
   logic continuous_ff, burstDone_ff, nxt_burstDone, waveActive_ff, stepPulse_ff, sweepDone_ff;
   logic trigPrev_ff, trigSync, trigRise, apbAccess, apbWrite, addrMapped, isRun, counterClear;
   logic prescaleHit, baseTick, intervalEnd, burstHit, lastInterval;

   // Trigger pin crosses in through two flops before edge detection
   fsp_sync u_trig_sync
   (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .asyncIn(triggerPin),
      .syncOut(trigSync)
   );

   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
         trigPrev_ff <= 1'b0;
      else
         trigPrev_ff <= trigSync;
   end

   assign trigRise = trigSync && !trigPrev_ff;

   // APB slave: one wait state, write lands on the completing edge
   assign apbAccess = psel && penable;
   assign apbWrite = apbAccess && pwrite && pready_ff;
   assign addrMapped = (paddr == `FSP_OFF_CMD) || (paddr == `FSP_OFF_STATUS) ||
                       (paddr == `FSP_OFF_FREQ) || (paddr == `FSP_OFF_CONFIG);
   assign cmdWord = pwdata[15:0];

   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         pready_ff <= 1'b0;
         pslverr_ff <= 1'b0;
         prdata_ff <= 32'h0000_0000;
      end
      else
      begin
         pready_ff <= apbAccess && !pready_ff;
         pslverr_ff <= apbAccess && !pready_ff && !addrMapped;
         if (apbAccess && !pready_ff && !pwrite)
         begin
            case (paddr)
               `FSP_OFF_STATUS:
                  prdata_ff <= {isRun, waveActive_ff, 18'h0_0000, stepIdx_ff};
               `FSP_OFF_FREQ:
                  prdata_ff <= {8'h00, freq_ff};
               `FSP_OFF_CONFIG:
                  prdata_ff <= {24'h00_0000, 3'h0, burstUnitClk_ff, intUnitClk_ff, stepDown_ff,
                                continuous_ff, fullWidth_ff};
               default:
                  prdata_ff <= 32'h0000_0000;
            endcase
         end
         // Cleared on the completing edge too, so data never outlives pready
         else
            prdata_ff <= 32'h0000_0000;
      end
   end

   // Control word decode; only the command offset accepts words
   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         fullWidth_ff <= `FSP_RST_FULL_WIDTH;
         continuous_ff <= `FSP_RST_CONTINUOUS;
      end
      else if (apbWrite && paddr == `FSP_OFF_CMD && cmdWord[15:12] == `FSP_SEL4_CONTROL)
      begin
         fullWidth_ff <= cmdWord[`FSP_BIT_FULL_WIDTH];
         continuous_ff <= cmdWord[`FSP_BIT_CONTINUOUS];
      end
   end

   // Start frequency: in full-width mode the low half waits for the high write
   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         startLow_ff <= 12'h000;
         startHigh_ff <= 12'h000;
         pendLow_ff <= 12'h000;
      end
      else if (apbWrite && paddr == `FSP_OFF_CMD)
      begin
         if (cmdWord[15:12] == `FSP_SEL4_START_LO)
         begin
            if (fullWidth_ff)
               pendLow_ff <= cmdWord[11:0];
            else
               startLow_ff <= cmdWord[11:0];
         end
         else if (cmdWord[15:12] == `FSP_SEL4_START_HI)
         begin
            startHigh_ff <= cmdWord[11:0];
            if (fullWidth_ff)
               startLow_ff <= pendLow_ff;
         end
      end
   end

   // Increment value, direction and step count
   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         stepLow_ff <= 12'h000;
         stepHigh_ff <= 11'h000;
         stepDown_ff <= 1'b0;
         stepCount_ff <= 12'h000;
      end
      else if (apbWrite && paddr == `FSP_OFF_CMD)
      begin
         case (cmdWord[15:12])
            `FSP_SEL4_STEP_LO:
               stepLow_ff <= cmdWord[11:0];
            `FSP_SEL4_STEP_HI:
            begin
               stepHigh_ff <= cmdWord[10:0];
               stepDown_ff <= cmdWord[`FSP_BIT_DIRECTION];
            end
            `FSP_SEL4_COUNT:
               stepCount_ff <= cmdWord[11:0];
            default:
               stepCount_ff <= stepCount_ff;
         endcase
      end
   end

   // Interval and burst words
   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         intCount_ff <= 11'h000;
         intUnitClk_ff <= 1'b0;
         intMult_ff <= 2'b00;
         burstCount_ff <= 11'h000;
         burstUnitClk_ff <= 1'b0;
      end
      else if (apbWrite && paddr == `FSP_OFF_CMD)
      begin
         if (cmdWord[15:14] == `FSP_SEL2_INTERVAL)
         begin
            intUnitClk_ff <= cmdWord[`FSP_BIT_UNIT_CLK];
            intMult_ff <= cmdWord[`FSP_MULT_HI:`FSP_MULT_LO];
            intCount_ff <= cmdWord[10:0];
         end
         else if ((cmdWord[15:13] | 3'h1) == (`FSP_SEL3_BURST | 3'h1))
         begin
            burstCount_ff <= cmdWord[10:0];
            burstUnitClk_ff <= cmdWord[`FSP_BIT_UNIT_CLK];
         end
      end
   end

   // Base tick: master clock scaled by the multiplier, or one output cycle.
   // Burst timing shares this tick, so its own unit bit is only read back over APB.
   always_comb
   begin
      case (intMult_ff)
         2'b00: multLimit = `FSP_MULT_X1;
         2'b01: multLimit = `FSP_MULT_X5;
         2'b10: multLimit = `FSP_MULT_X100;
         2'b11: multLimit = `FSP_MULT_X500;
         default: multLimit = `FSP_MULT_X1;
      endcase
   end

   assign isRun = (state_ff == FSP_RUN);
   assign counterClear = trigRise || !isRun;

   fsp_tick_counter #(.W(9)) u_prescale
   (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .clear(counterClear),
      .tick(intUnitClk_ff),
      .limit(multLimit),
      .hit(prescaleHit)
   );

   // Unit select follows the interval word only
   assign baseTick = intUnitClk_ff ? prescaleHit : (waveCycleTick && !counterClear);

   fsp_tick_counter #(.W(11)) u_interval
   (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .clear(counterClear),
      .tick(baseTick),
      .limit(intCount_ff),
      .hit(intervalEnd)
   );

   fsp_tick_counter #(.W(11)) u_burst
   (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .clear(counterClear || intervalEnd),
      .tick(baseTick && !burstDone_ff),
      .limit(burstCount_ff),
      .hit(burstHit)
   );

   // Sequencer: count plus one intervals, the last one at the final frequency
   assign lastInterval = (stepIdx_ff == stepCount_ff);
   assign stepExt = {1'b0, stepHigh_ff, stepLow_ff};

   always_comb
   begin
      nxt_state = state_ff;
      case (state_ff)
         FSP_IDLE:
            if (trigRise)
               nxt_state = FSP_RUN;
         FSP_RUN:
            if (!trigRise && intervalEnd && lastInterval)
               nxt_state = FSP_IDLE;
         default:
            nxt_state = FSP_IDLE;
      endcase
   end

   // Additions and subtractions simply wrap in 24 bits
   always_comb
   begin
      if (stepDown_ff)
         nxt_freq = freq_ff - stepExt;
      else
         nxt_freq = freq_ff + stepExt;
   end

   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
         state_ff <= FSP_IDLE;
      else
         state_ff <= nxt_state;
   end

   // A trigger edge mid-sweep restarts from the stored start frequency
   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         freq_ff <= 24'h00_0000;
         stepIdx_ff <= 12'h000;
      end
      else if (trigRise)
      begin
         freq_ff <= {startHigh_ff, startLow_ff};
         stepIdx_ff <= 12'h000;
      end
      else if (isRun && intervalEnd && !lastInterval)
      begin
         freq_ff <= nxt_freq;
         stepIdx_ff <= stepIdx_ff + 12'h001;
      end
   end

   always_comb
   begin
      if (counterClear || intervalEnd)
         nxt_burstDone = 1'b0;
      else
         nxt_burstDone = burstDone_ff || burstHit;
   end

   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
         burstDone_ff <= 1'b0;
      else
         burstDone_ff <= nxt_burstDone;
   end

   // Outputs: midscale is shown as waveActive low
   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         waveActive_ff <= 1'b0;
         stepPulse_ff <= 1'b0;
         sweepDone_ff <= 1'b0;
      end
      else
      begin
         waveActive_ff <= (nxt_state == FSP_RUN) &&
                          (continuous_ff || trigRise || !nxt_burstDone);
         stepPulse_ff <= isRun && !trigRise && intervalEnd && !lastInterval;
         sweepDone_ff <= isRun && !trigRise && intervalEnd && lastInterval;
      end
   end

   assign prdata = prdata_ff;
   assign pready = pready_ff;
   assign pslverr = pslverr_ff;
   assign freqWord = freq_ff;
   assign waveActive = waveActive_ff;
   // RUN owns the high one-hot bit, so busy is the state flop itself
   assign sweepBusy = state_ff[1];
   assign stepPulse = stepPulse_ff;
   assign sweepDonePulse = sweepDone_ff;
endmodule

// ===== src/fsp_sync.sv
// Two-flop synchroniser for a pin input
`timescale 1ns/10ps
module fsp_sync
(
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic asyncIn,
   output logic syncOut
);
   logic stage1_ff;
   logic stage2_ff;

   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         stage1_ff <= 1'b0;
         stage2_ff <= 1'b0;
      end
      else
      begin
         stage1_ff <= asyncIn;
         stage2_ff <= stage1_ff;
      end
   end

   assign syncOut = stage2_ff;
endmodule

// ===== src/fsp_tick_counter.sv
// Wrapping event counter that pulses when a programmed number of ticks is reached
`timescale 1ns/10ps
module fsp_tick_counter
#(
   parameter int W = 11
)
(
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic clear,
   input wire logic tick,
   input wire logic [W-1:0] limit,
   output logic hit
);
   logic [W-1:0] count_ff;
   logic [W-1:0] nxt_count;

   // A limit of zero hits only after the count wraps, 2^W ticks; a limit of one hits on every tick
   assign nxt_count = count_ff + {{(W-1){1'b0}}, 1'b1};
   assign hit = tick && !clear && (nxt_count == limit);

   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
         count_ff <= '0;
      else if (clear || hit)
         count_ff <= '0;
      else if (tick)
         count_ff <= nxt_count;
   end
endmodule

// ===== tb/fsp_sweep_monitor.sv
// Port-level checker for the sweep profile block
`timescale 1ns/10ps
module fsp_sweep_monitor
(
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire fsp_pkg::fsp_freq_t freqWord,
   input wire logic waveActive,
   input wire logic sweepBusy,
   input wire logic stepPulse,
   input wire logic sweepDonePulse
);
   import fsp_pkg::*;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   setup_wait_a: assert property (psel && !penable |=> !pready)
      else $error("pready without wait state");
   ready_due_a: assert property (psel && penable && !pready |=> pready)
      else $error("pready late");
   ready_once_a: assert property (pready |=> !pready)
      else $error("pready held");
   err_with_ready_a: assert property (pslverr |-> pready)
      else $error("pslverr without pready");
   rdata_idle_a: assert property (!pready |-> prdata == 32'h0)
      else $error("prdata not zero");
   idle_hold_a: assert property (!sweepBusy |-> $stable(freqWord))
      else $error("frequency moved while idle");
   start_active_a: assert property ($rose(sweepBusy) |-> waveActive && !stepPulse)
      else $error("sweep start wrong");
   step_in_sweep_a: assert property (stepPulse |-> sweepBusy && !sweepDonePulse)
      else $error("step outside sweep");
   step_gap_a: assert property (stepPulse |=> !stepPulse)
      else $error("steps too close");
   done_end_a: assert property (sweepDonePulse |-> !sweepBusy && $past(sweepBusy))
      else $error("done not at sweep end");
   idle_quiet_a: assert property (!sweepBusy |-> !waveActive)
      else $error("output active while idle");
endmodule

bind fsp_sweep_top fsp_sweep_monitor i_mon (.ref_clk(ref_clk), .rst_n(rst_n), .psel(psel),
   .penable(penable), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .freqWord(freqWord), .waveActive(waveActive), .sweepBusy(sweepBusy),
   .stepPulse(stepPulse), .sweepDonePulse(sweepDonePulse));

// ===== tb/fsp_wave_model.sv
// Output waveform cycle source feeding the sweep profile block
`timescale 1ns/10ps
module fsp_wave_model
#(
   parameter int PERIOD = 3
)
(
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic runEn,
   output logic waveCycleTick
);
   int tickCnt_ff;
   // Free-running phase, so the sweep can start anywhere within a cycle
   always_ff @(posedge ref_clk)
   begin
      if (!rst_n || !runEn)
      begin
         tickCnt_ff <= 0;
         waveCycleTick <= 1'h0;
      end
      else
      begin
         tickCnt_ff <= (tickCnt_ff == PERIOD - 1) ? 0 : tickCnt_ff + 1;
         waveCycleTick <= (tickCnt_ff == PERIOD - 1);
      end
   end
endmodule

// ===== tb/tb.sv
// Self-checking bench for the sweep profile block
`timescale 1ns/10ps
`include "fsp_map.svh"
module tb;
   import fsp_pkg::*;
   logic ref_clk = 1'h0;
   logic rst_n = 1'h0;
   logic psel = 1'h0;
   logic penable = 1'h0;
   logic pwrite = 1'h0;
   logic [7:0] paddr = 8'h0;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic triggerPin = 1'h0;
   logic tickEn = 1'h0;
   logic waveCycleTick;
   fsp_freq_t freqWord;
   logic waveActive;
   logic sweepBusy;
   logic stepPulse;
   logic sweepDonePulse;
   logic [31:0] rdat;
   logic rerr;
   int n_fail = 0;
   int comparisons = 0;
   int mult [4] = '{1, 5, 100, 500};

   always #2 ref_clk = ~ref_clk;

   fsp_sweep_top i_dut (.ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .triggerPin(triggerPin), .waveCycleTick(waveCycleTick),
      .freqWord(freqWord), .waveActive(waveActive), .sweepBusy(sweepBusy),
      .stepPulse(stepPulse), .sweepDonePulse(sweepDonePulse));
   fsp_wave_model #(.PERIOD(3)) i_wave (.ref_clk(ref_clk), .rst_n(rst_n), .runEn(tickEn),
      .waveCycleTick(waveCycleTick));

   task automatic chk(input bit ok, input string msg);
      comparisons++;
      if (!ok)
      begin
         n_fail++;
         $display("CHECK FAILED at %0t: %s", $time, msg);
      end
   endtask

   task automatic wrap_up;
      $display("%0d mismatches in %0d comparisons", n_fail, comparisons);
      if (n_fail == 0 && comparisons > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   // Entered just after a rising edge; leaves one idle cycle so no strobe is set twice
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'h1;
      penable <= 1'h0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'h1;
      // No local limit: only the watchdog may end a wait for pready
      do
      begin
         @(posedge ref_clk);
      end
      while (pready !== 1'h1);
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
      @(posedge ref_clk);
   endtask

   task automatic cmd(input logic [15:0] w);
      apb(1'h1, `FSP_OFF_CMD, {16'h0, w});
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic err, input string m);
      apb(1'h0, a, 32'h0);
      chk(rdat === exp && rerr === err, m);
   endtask

   // Triggers a sweep and follows every step; tol covers base-tick phase
   task automatic run(input fsp_freq_t s, input fsp_freq_t d, input logic dn, input int n,
      input int per, input int tol, input logic gated);
      fsp_freq_t e;
      int c;
      int k;
      int lowCnt;
      triggerPin <= 1'h1;
      c = 0;
      while (sweepBusy !== 1'h1 && c < 20)
      begin
         @(posedge ref_clk);
         #1;
         c++;
      end
      e = s;
      chk(sweepBusy === 1'h1 && freqWord === e, "first frequency");
      c = 0;
      k = 0;
      lowCnt = 0;
      while (sweepDonePulse !== 1'h1 && c < 20000)
      begin
         @(posedge ref_clk);
         #1;
         c++;
         lowCnt += (sweepBusy === 1'h1 && waveActive !== 1'h1);
         if (stepPulse === 1'h1)
         begin
            e = dn ? e - d : e + d;
            k++;
            chk(freqWord === e, "step frequency");
         end
      end
      chk(k == n && freqWord === e, "final frequency");
      chk(c >= (n + 1) * per - tol && c <= (n + 1) * per + tol, "sweep length");
      chk((lowCnt > 0) == gated, "burst gating");
      @(posedge ref_clk);
      triggerPin <= 1'h0;
      repeat (4) @(posedge ref_clk);
   endtask

   initial
   begin
      repeat (16) @(posedge ref_clk);
      rst_n <= 1'h1;
      @(posedge ref_clk);
      rd(`FSP_OFF_CONFIG, 32'h3, 1'h0, "config reset");
      rd(`FSP_OFF_STATUS, 32'h0, 1'h0, "status reset");
      rd(8'h10, 32'h0, 1'h1, "unmapped address");
      apb(1'h1, `FSP_OFF_CONFIG, 32'h0);
      rd(`FSP_OFF_CONFIG, 32'h3, 1'h0, "config read only");
      rd(`FSP_OFF_CMD, 32'h0, 1'h0, "command reads zero");
      cmd(16'hc456);
      cmd(16'hd123);
      cmd(16'h2801);
      cmd(16'h3405);
      cmd(16'h1003);
      cmd(16'h6002);
      run(24'h123456, 24'h405801, 1'h0, 3, 2, 0, 1'h0);
      // Downward through zero, so the word must wrap
      cmd(16'hc010);
      cmd(16'hd000);
      cmd(16'h2020);
      cmd(16'h3800);
      cmd(16'h1002);
      for (int m = 0; m < 4; m++)
      begin
         cmd({3'h3, m[1:0], 11'h002});
         run(24'h000010, 24'h000020, 1'h1, 2, 2 * mult[m], mult[m], 1'h0);
      end
      cmd(16'h0080);
      cmd(16'h6002);
      cmd(16'hd0ab);
      run(24'h0ab010, 24'h000020, 1'h1, 2, 2, 0, 1'h0);
      cmd(16'hc777);
      run(24'h0ab777, 24'h000020, 1'h1, 2, 2, 0, 1'h0);
      tickEn <= 1'h1;
      cmd(16'h0800);
      cmd(16'ha001);
      cmd(16'h4002);
      rd(`FSP_OFF_CONFIG, 32'h15, 1'h0, "burst unit stored");
      run(24'h0ab777, 24'h000020, 1'h1, 2, 6, 3, 1'h1);
      wrap_up;
   end

   initial
   begin
      repeat (30000) @(posedge ref_clk);
      n_fail++;
      wrap_up;
   end
endmodule
